// *** rtl/tcw_wavegen.sv ***
// Timer counter with compare outputs behind an AXI4-Lite register slave
module tcw_wavegen
(
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    // Timer clock enable from the clock select logic
    input  wire logic                        timer_clock_enable,
    // Port pin interface
    input  wire logic                        port_value_a,
    input  wire logic                        port_value_b,
    input  wire logic                        compare_pin_direction_a,
    input  wire logic                        compare_pin_direction_b,
    output logic                             output_a,
    output logic                             output_a_oe,
    output logic                             output_b,
    output logic                             output_b_oe,
    // AXI4-Lite write address
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [tcw_pkg::ADDR_W-1:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    // AXI4-Lite write response
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    output logic [1:0]                       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    input  wire logic [tcw_pkg::ADDR_W-1:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp
);
    import tcw_pkg::*;

    typedef struct packed {
        logic [7:0]        counter_value, cmpa_buf, cmpb_buf, cmpa_act, cmpb_act;
        logic [2:0]        wgm;
        logic [1:0]        com_a, com_b;
        logic              overflow_flag, compare_flag_a, compare_flag_b, block;
        logic              aw_held, w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0]        wdata;
        logic              wstrb0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } tcw_state_t;

    tcw_state_t st_ff;
    tcw_state_t nxt_st;

    // Word address of a byte address
    function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] addr);
        word_of = {addr[7:2], 2'b00};
    endfunction

    // Whether a byte address hits a register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        case (word_of(addr))
            OFF_CTRL, OFF_COUNT, OFF_CMPA, OFF_CMPB, OFF_FLAGS, OFF_FORCE:
                is_mapped = 1'b1;
            default:
                is_mapped = 1'b0;
        endcase
    endfunction

    // counting class from mode select only
    function automatic tcw_mode_t mode_of(input logic [2:0] wgm);
        case (wgm)
            WGM_CTC:                     mode_of = TCW_CTC;
            WGM_FAST_MAX, WGM_FAST_CMPA: mode_of = TCW_FAST;
            default:                     mode_of = TCW_NORMAL;
        endcase
    endfunction

    tcw_mode_t  mode;
    logic       tick, wr_fire, wr_en, wr_cnt, wr_force;
    logic [7:0] wr_word, cmpa_eff, cmpb_eff, top_val;
    logic       at_top, match_a, match_b, wrap_evt, ovf_set, oc_a, oc_b;

    assign tick = timer_clock_enable;
    assign mode = mode_of(st_ff.wgm);

    // Bus handshakes and decoded write strobes
    assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
    assign s_axi_wready  = !st_ff.w_held && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign wr_fire  = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    assign wr_en    = wr_fire && st_ff.wstrb0 && is_mapped(st_ff.awaddr);
    assign wr_word  = word_of(st_ff.awaddr);
    assign wr_cnt   = wr_en && (wr_word == OFF_COUNT);
    assign wr_force = wr_en && (wr_word == OFF_FORCE);

    // buffered compare only in fast PWM
    assign cmpa_eff = (mode == TCW_FAST) ? st_ff.cmpa_act : st_ff.cmpa_buf;
    assign cmpb_eff = (mode == TCW_FAST) ? st_ff.cmpb_act : st_ff.cmpb_buf;

    assign top_val = (st_ff.wgm == WGM_FAST_CMPA) ? cmpa_eff : CNT_MAX;

    // matches blocked after a counter write
    assign match_a = tick && (st_ff.counter_value == cmpa_eff) && !st_ff.block;
    assign match_b = tick && (st_ff.counter_value == cmpb_eff) && !st_ff.block;

    // CLEAR_ON_MATCH_MODE clears on compare A, fast PWM at TOP
    assign at_top = (mode == TCW_CTC) ? match_a :
                    ((mode == TCW_FAST) && (st_ff.counter_value == top_val));

    // wrap event from TOP to BOTTOM in fast PWM
    assign wrap_evt = tick && !wr_cnt && (mode == TCW_FAST) && at_top;

    // overflow on MAX to zero in CLEAR_ON_MATCH_MODE
    // overflow at TOP in fast PWM
    assign ovf_set = tick && !wr_cnt &&
                     ((mode == TCW_FAST) ? at_top : (st_ff.counter_value == CNT_MAX));

    // Next state of counter, flags, registers and bus
    always_comb
    begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        nxt_st = st_ff;

        // Capture write address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata  = s_axi_wdata[7:0];
            nxt_st.wstrb0 = s_axi_wstrb[0];
        end
        if (st_ff.bvalid && s_axi_bready)
            nxt_st.bvalid = 1'b0;
        if (wr_fire)
        begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = is_mapped(st_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Register writes; action select takes effect at once
        // action select unbuffered
        if (wr_en && wr_word == OFF_CTRL)
        begin
            nxt_st.wgm   = st_ff.wdata[CTRL_WGM_LSB +: 3];
            nxt_st.com_b = st_ff.wdata[CTRL_COMB_LSB +: 2];
            nxt_st.com_a = st_ff.wdata[CTRL_COMA_LSB +: 2];
        end
        if (wr_en && wr_word == OFF_CMPA)
            nxt_st.cmpa_buf = st_ff.wdata;
        if (wr_en && wr_word == OFF_CMPB)
            nxt_st.cmpb_buf = st_ff.wdata;

        // active compare loads at the wrap in fast PWM
        if (mode != TCW_FAST || wrap_evt)
        begin
            nxt_st.cmpa_act = st_ff.cmpa_buf;
            nxt_st.cmpb_act = st_ff.cmpb_buf;
        end

        // software write beats count and clear
        if (wr_cnt)
            nxt_st.counter_value = st_ff.wdata;
        // counting only on timer clock enable
        else if (tick)
        begin
            if (at_top)
                nxt_st.counter_value = CNT_BOTTOM;
            else
                nxt_st.counter_value = 8'(st_ff.counter_value + 8'h01);
        end

        // block the next timer cycle after a counter write
        if (wr_cnt)
            nxt_st.block = 1'b1;
        else if (tick)
            nxt_st.block = 1'b0;

        // flags set by hardware win over write-one clear
        if (wr_en && wr_word == OFF_FLAGS)
        begin
            if (st_ff.wdata[FLG_OVF])
                nxt_st.overflow_flag = 1'b0;
            if (st_ff.wdata[FLG_CMPA])
                nxt_st.compare_flag_a = 1'b0;
            if (st_ff.wdata[FLG_CMPB])
                nxt_st.compare_flag_b = 1'b0;
        end
        if (ovf_set)
            nxt_st.overflow_flag = 1'b1;
        if (match_a)
            nxt_st.compare_flag_a = 1'b1;
        if (match_b)
            nxt_st.compare_flag_b = 1'b1;

        // Read data mux, unused bits read zero
        case (word_of(s_axi_araddr))
            OFF_CTRL:
            begin
                rd[CTRL_WGM_LSB +: 3]  = st_ff.wgm;
                rd[CTRL_COMB_LSB +: 2] = st_ff.com_b;
                rd[CTRL_COMA_LSB +: 2] = st_ff.com_a;
            end
            OFF_COUNT: rd[7:0] = st_ff.counter_value;
            OFF_CMPA:  rd[7:0] = st_ff.cmpa_buf;
            OFF_CMPB:  rd[7:0] = st_ff.cmpb_buf;
            OFF_FLAGS:
            begin
                rd[FLG_OVF]  = st_ff.overflow_flag;
                rd[FLG_CMPA] = st_ff.compare_flag_a;
                rd[FLG_CMPB] = st_ff.compare_flag_b;
                rd[FLG_OCA]  = oc_a;
                rd[FLG_OCB]  = oc_b;
            end
            default:   rd = 32'h0000_0000;
        endcase
        if (st_ff.rvalid && s_axi_rready)
            nxt_st.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd;
            nxt_st.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_ff               <= '0;
            st_ff.counter_value <= RST_COUNT;
            st_ff.cmpa_buf      <= RST_CMP;
            st_ff.cmpb_buf      <= RST_CMP;
            st_ff.cmpa_act      <= RST_CMP;
            st_ff.cmpb_act      <= RST_CMP;
            st_ff.wgm           <= RST_WGM;
            st_ff.com_a         <= RST_COM;
            st_ff.com_b         <= RST_COM;
        end
        else
            st_ff <= nxt_st;
    end

    // Output state units; force skips flags and counter
    // force only reaches output state
    // output state independent of mode changes
    tcw_oc_unit u_oc_a
    (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .pwm_mode   (mode == TCW_FAST),
        .com        (st_ff.com_a),
        .toggle_ok  (st_ff.wgm[2]),
        .match      (match_a),
        .bottom_evt (wrap_evt),
        .force_cmp  (wr_force && st_ff.wdata[FRC_A]),
        .oc_state   (oc_a)
    );

    // channel B never toggles in fast PWM
    tcw_oc_unit u_oc_b
    (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .pwm_mode   (mode == TCW_FAST),
        .com        (st_ff.com_b),
        .toggle_ok  (1'b0),
        .match      (match_b),
        .bottom_evt (wrap_evt),
        .force_cmp  (wr_force && st_ff.wdata[FRC_B]),
        .oc_state   (oc_b)
    );

    // pin override by nonzero action select
    assign output_a    = (st_ff.com_a != COM_NONE) ? oc_a : port_value_a;
    assign output_b    = (st_ff.com_b != COM_NONE) ? oc_b : port_value_b;
    assign output_a_oe = compare_pin_direction_a;
    assign output_b_oe = compare_pin_direction_b;

    // Bus outputs from the state register
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp  = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata  = st_ff.rdata;
    assign s_axi_rresp  = st_ff.rresp;

    default clocking cb @(posedge clk_sys);
    endclocking

    a_block_match: assert property (disable iff (srst)
        (st_ff.block && tick && !st_ff.compare_flag_a) |=> !st_ff.compare_flag_a)
        else $error("compare flag set in blocked cycle");
    a_reset_oc: assert property (
        srst |=> (!oc_a && !oc_b))
        else $error("output state not cleared by reset");
    a_normal_wrap: assert property (disable iff (srst)
        (st_ff.wgm == WGM_NORMAL && tick && !wr_cnt && st_ff.counter_value == CNT_MAX)
        |=> (st_ff.counter_value == CNT_BOTTOM) && st_ff.overflow_flag)
        else $error("normal mode wrap or overflow wrong");
    a_ctc_clear: assert property (disable iff (srst)
        (mode == TCW_CTC && !wr_cnt && match_a)
        |=> (st_ff.counter_value == CNT_BOTTOM) && st_ff.compare_flag_a)
        else $error("CLEAR_ON_MATCH_MODE match did not clear counter and set flag");
    a_fast_top: assert property (disable iff (srst)
        (mode == TCW_FAST && tick && !wr_cnt && st_ff.counter_value == top_val)
        |=> (st_ff.counter_value == CNT_BOTTOM) && st_ff.overflow_flag)
        else $error("fast PWM did not clear at TOP");
    a_write_prio: assert property (disable iff (srst)
        wr_cnt |=> (st_ff.counter_value == $past(st_ff.wdata)))
        else $error("counter write lost to hardware update");
    a_idle_hold: assert property (disable iff (srst)
        (!tick && !wr_cnt) |=> $stable(st_ff.counter_value) ##1 1'b1)
        else $error("counter moved without timer clock");
    a_dbuf_hold: assert property (disable iff (srst)
        (mode == TCW_FAST && !wrap_evt && $past(mode) == TCW_FAST)
        |=> $stable(st_ff.cmpa_act))
        else $error("buffered compare changed off the wrap");
    a_oc_keep: assert property (disable iff (srst)
        (!tick && !wr_force) |=> ($stable(oc_a) && $stable(oc_b)))
        else $error("output state changed with no event");
endmodule // tcw_wavegen

// *** rtl/tcw_pkg.sv ***
// Shared constants and types of the timer compare waveform generator
package tcw_pkg;

    // Register bus geometry
    localparam int          ADDR_W        = 8;

    // Register byte offsets
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_COUNT     = 8'h04;
    localparam logic [7:0]  OFF_CMPA      = 8'h08;
    localparam logic [7:0]  OFF_CMPB      = 8'h0C;
    localparam logic [7:0]  OFF_FLAGS     = 8'h10;
    localparam logic [7:0]  OFF_FORCE     = 8'h14;

    // Control register field positions
    localparam int          CTRL_WGM_LSB  = 0;
    localparam int          CTRL_COMB_LSB = 4;
    localparam int          CTRL_COMA_LSB = 6;

    // Flag register bit positions, oc bits are read only
    localparam int          FLG_OVF       = 0;
    localparam int          FLG_CMPA      = 1;
    localparam int          FLG_CMPB      = 2;
    localparam int          FLG_OCA       = 4;
    localparam int          FLG_OCB       = 5;

    // Force strobe bit positions
    localparam int          FRC_A         = 0;
    localparam int          FRC_B         = 1;

    // Reset values
    localparam logic [7:0]  RST_COUNT     = 8'h00;
    localparam logic [7:0]  RST_CMP       = 8'h00;
    localparam logic [2:0]  RST_WGM       = 3'h0;
    localparam logic [1:0]  RST_COM       = 2'h0;
    localparam logic        RST_OC        = 1'b0;

    // Waveform mode select codes
    localparam logic [2:0]  WGM_NORMAL    = 3'h0;
    localparam logic [2:0]  WGM_CTC       = 3'h2;
    localparam logic [2:0]  WGM_FAST_MAX  = 3'h3;
    localparam logic [2:0]  WGM_FAST_CMPA = 3'h7;

    // Counter extremes
    localparam logic [7:0]  CNT_MAX       = 8'hFF;
    localparam logic [7:0]  CNT_BOTTOM    = 8'h00;

    // Output action select codes
    localparam logic [1:0]  COM_NONE      = 2'h0;
    localparam logic [1:0]  COM_TOGGLE    = 2'h1;
    localparam logic [1:0]  COM_CLEAR     = 2'h2;
    localparam logic [1:0]  COM_SET       = 2'h3;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Counting behaviour classes
    typedef enum logic [1:0] {TCW_NORMAL, TCW_CTC, TCW_FAST} tcw_mode_t;

endpackage

// *** rtl/tcw_oc_unit.sv ***
// Compare output state of one channel
module tcw_oc_unit
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Mode and action
    input  wire logic        pwm_mode,
    input  wire logic [1:0]  com,
    input  wire logic        toggle_ok,
    // Events
    input  wire logic        match,
    input  wire logic        bottom_evt,
    input  wire logic        force_cmp,
    // State
    output logic             oc_state
);
    import tcw_pkg::*;

    typedef struct packed {
        logic oc;
    } tcw_oc_state_t;

    tcw_oc_state_t st_ff;
    tcw_oc_state_t nxt_st;

    // Next output state from action select and events
    always_comb
    begin
        nxt_st = st_ff;
        if (!pwm_mode)
        begin
            if (match || force_cmp)
            begin
                case (com)
                    COM_TOGGLE: nxt_st.oc = ~st_ff.oc;
                    COM_CLEAR:  nxt_st.oc = 1'b0;
                    COM_SET:    nxt_st.oc = 1'b1;
                    default:    nxt_st.oc = st_ff.oc;
                endcase
            end
        end
        else
        begin
            case (com)
                COM_TOGGLE:
                    if (match && toggle_ok)
                        nxt_st.oc = ~st_ff.oc;
                COM_CLEAR:
                    if (bottom_evt)
                        nxt_st.oc = 1'b1;
                    else if (match)
                        nxt_st.oc = 1'b0;
                COM_SET:
                    if (bottom_evt)
                        nxt_st.oc = 1'b0;
                    else if (match)
                        nxt_st.oc = 1'b1;
                default:
                    nxt_st.oc = st_ff.oc;
            endcase
        end
    end

    // State register, cleared by reset
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            st_ff.oc <= RST_OC;
        else
            st_ff <= nxt_st;
    end

    assign oc_state = st_ff.oc;

    a_zero_noop: assert property (@(posedge clk_sys) disable iff (srst)
        (com == COM_NONE) |=> $stable(oc_state))
        else $error("output state moved with zero action select");

    a_force_set: assert property (@(posedge clk_sys) disable iff (srst)
        (!pwm_mode && force_cmp && com == COM_SET) |=> oc_state)
        else $error("forced set did not reach output state");

endmodule // tcw_oc_unit

// *** dv/tcw_pin_load.sv ***
// Port pin model: external load with pull-up on a compare output pin
module tcw_pin_load
(
    // Pin drive from the block
    input  wire logic drv,
    input  wire logic oe,
    // Level seen on the wire
    output logic      level
);
    timeunit 1ns;
    timeprecision 1ps;
    assign level = oe ? drv : 1'b1; // Pull-up when released
endmodule // tcw_pin_load

// *** dv/tcw_wavegen_tb.sv ***
// Self-checking bench for the timer compare waveform generator
module tcw_wavegen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcw_pkg::*;
    logic        clk_sys = 1'b0, srst = 1'b1, timer_clock_enable = 1'b0;
    logic        port_value_a = 1'b1, port_value_b = 1'b0;
    logic        compare_pin_direction_a = 1'b1, compare_pin_direction_b = 1'b0;
    logic        output_a, output_a_oe, output_b, output_b_oe, pin_a, pin_b;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [7:0]  rd;
    int          mismatches = 0, check_count = 0, cyc = 0;
    // Clock of 4 ns period
    always #2 clk_sys = ~clk_sys;
    tcw_wavegen DUT (.clk_sys, .srst, .timer_clock_enable, .port_value_a, .port_value_b,
        .compare_pin_direction_a, .compare_pin_direction_b, .output_a, .output_a_oe,
        .output_b, .output_b_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    tcw_pin_load load_a (.drv(output_a), .oe(output_a_oe), .level(pin_a));
    tcw_pin_load load_b (.drv(output_b), .oe(output_b_oe), .level(pin_b));
    // Compare one byte value
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // AXI4-Lite write of one register byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok, w_ok, ta, tw;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            ta = s_axi_awready && !aw_ok;
            tw = s_axi_wready && !w_ok;
            @(posedge clk_sys);
            if (ta) begin s_axi_awvalid <= 1'b0; aw_ok = 1'b1; end
            if (tw) begin s_axi_wvalid <= 1'b0; w_ok = 1'b1; end
        end while (!(aw_ok && w_ok));
        do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        @(posedge clk_sys);
        s_axi_bready <= 1'b0;
    endtask
    // AXI4-Lite read of one register byte
    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        @(posedge clk_sys);
        s_axi_rready <= 1'b0;
    endtask
    // Exactly n timer ticks
    task automatic tick(input int n);
        @(posedge clk_sys);
        timer_clock_enable <= 1'b1;
        repeat (n) @(posedge clk_sys);
        timer_clock_enable <= 1'b0;
    endtask
    // Reset state, pin mux and forced compare in normal mode
    task automatic t_force;
        rdr(OFF_FLAGS);
        chk("flags after reset", 8'h00, rd);
        chk("pin follows port", 8'h01, {7'h0, pin_a});
        chk("pin b released", 8'h01, {7'h0, pin_b});
        chk("output b port", 8'h00, {7'h0, output_b});
        wr(OFF_CTRL, 8'hC0);
        @(negedge clk_sys);
        chk("pin before force", 8'h00, {7'h0, pin_a});
        wr(OFF_FORCE, 8'h01);
        @(negedge clk_sys);
        chk("pin after force", 8'h01, {7'h0, pin_a});
        wr(OFF_CTRL, 8'h42);
        rdr(OFF_FLAGS);
        chk("flags after force", 8'h10, rd);
    endtask
    // Clear on match with toggle on output A
    task automatic t_ctc;
        // count written away from every compare value
        wr(OFF_CMPA, 8'h03);
        wr(OFF_CMPB, 8'h02);
        wr(OFF_COUNT, 8'h00);
        tick(5);
        rdr(OFF_COUNT);
        chk("ctc count", 8'h01, rd);
        rdr(OFF_FLAGS);
        chk("ctc flags", 8'h06, rd);
    endtask
    // Normal mode wrap, overflow and blocked match
    task automatic t_wrap;
        wr(OFF_FLAGS, 8'h07);
        wr(OFF_CTRL, 8'h00);
        wr(OFF_COUNT, 8'hFE);
        tick(2);
        rdr(OFF_COUNT);
        chk("wrap count", 8'h00, rd);
        rdr(OFF_FLAGS);
        chk("overflow flag", 8'h01, rd);
        wr(OFF_COUNT, 8'h02);
        tick(1);
        rdr(OFF_FLAGS);
        chk("blocked match", 8'h01, rd);
        wr(8'h18, 8'h55);
        chk("unmapped bresp", {6'h0, RESP_SLVERR}, {6'h0, resp});
        rdr(8'h18);
        chk("unmapped resp", {6'h0, RESP_SLVERR}, {6'h0, resp});
        chk("unmapped data", 8'h00, rd);
    endtask
    // Fast PWM with TOP at compare A, buffered compare and polarity
    task automatic t_fast;
        // count written away from every compare value
        wr(OFF_FLAGS, 8'h07);
        wr(OFF_CMPA, 8'h04);
        wr(OFF_COUNT, 8'h00);
        wr(OFF_CTRL, 8'hB7);
        wr(OFF_CMPA, 8'h02);
        tick(4);
        rdr(OFF_COUNT);
        chk("fast count", 8'h04, rd);
        rdr(OFF_FLAGS);
        chk("fast flags", 8'h24, rd);
        tick(1);
        rdr(OFF_COUNT);
        chk("fast wrap count", 8'h00, rd);
        rdr(OFF_FLAGS);
        chk("fast wrap flags", 8'h17, rd);
        chk("pin a pwm", 8'h01, {7'h0, pin_a});
    endtask
    // Verdict and end of run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Cycle limit against hangs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        t_force();
        t_ctc();
        t_wrap();
        t_fast();
        print_verdict();
    end
endmodule // tcw_wavegen_tb
